// ---- touch_detect_regs.svh ----
// Constants for the touch detection output and drift block
`ifndef TOUCH_DETECT_REGS_SVH
`define TOUCH_DETECT_REGS_SVH

`define TD_CNT_W 14
`define TD_THRESH 14'h000A
`define TD_HYST 14'h0002
`define TD_CONSENSUS 3'h4
`define TD_CLK_MHZ 40
`define TD_LIVE_NS 15000
`define TD_LIVE_CYC ((`TD_LIVE_NS * `TD_CLK_MHZ + 999) / 1000)
`define TD_FAST_GAP_US 1200
`define TD_FAST_GAP_CYC (`TD_FAST_GAP_US * `TD_CLK_MHZ)
`define TD_SLEEP_GAP_MS 80
`define TD_SLEEP_GAP_CYC (`TD_SLEEP_GAP_MS * 1000 * `TD_CLK_MHZ)
`define TD_MAX_ON_BURSTS 727
`define TD_DRIFT_DOWN_BURSTS 5'h02
`define TD_DRIFT_UP_BURSTS 5'h10
`define TD_TIMER_W 22
`define TD_ON_W 12
`define TD_DITHER_PCT_X10 75
`define TD_DITHER_STEP_X10 5
`define TD_DITHER_MAX (`TD_DITHER_PCT_X10 / `TD_DITHER_STEP_X10)
`define TD_LFSR_SEED 8'hA5

`endif

// ---- touch_detect_pkg.sv ----
// Types shared by the touch detection block and its dither generator
`include "touch_detect_regs.svh"
package touch_detect_pkg;
    typedef enum logic [1:0] {PACE_GAP, PACE_LIVE, PACE_BURST} pace_e;

    typedef struct packed {
        pace_e st;
        logic [`TD_TIMER_W-1:0] timer;
        logic [`TD_CNT_W-1:0] ref_lvl;
        logic [2:0] di;
        logic out;
        logic cal;
        logic [`TD_ON_W-1:0] on_cnt;
        logic [4:0] drift_cnt;
    } detect_s;

    typedef struct packed {
        logic [7:0] lfsr;
        logic signed [4:0] trim;
    } dither_s;
endpackage : touch_detect_pkg

// ---- spread_dither.sv ----
// Pseudo-random oscillator trim for spread-spectrum bursts
`timescale 1ns/1ps
`include "touch_detect_regs.svh"
module spread_dither (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Control and trim
    input wire logic active,
    output logic signed [4:0] osc_trim
);
    touch_detect_pkg::dither_s q, d;

    always_comb
    begin
        d = q;
        if (active)
        begin
            d.lfsr = {q.lfsr[6:0], q.lfsr[7] ^ q.lfsr[5] ^ q.lfsr[4] ^ q.lfsr[3]};
            // Fold 0..31 into -15..15 steps of 0.5 percent
            if (q.lfsr[4:0] > 5'(2 * `TD_DITHER_MAX))
                d.trim = 5'sh00;
            else
                d.trim = 5'(q.lfsr[4:0] - 5'(`TD_DITHER_MAX)); // [R7]
        end
        else
        begin
            d.trim = 5'sh00;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            q.lfsr <= `TD_LFSR_SEED;
            q.trim <= 5'sh00;
        end
        else
        begin
            q <= d;
        end
    end

    assign osc_trim = q.trim;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_trim_in_range: assert property (osc_trim <= 5'sh0F && osc_trim >= -5'sh0F) // [R7]
        else $error("Oscillator trim outside spread range");
    a_trim_idle_zero: assert property (!$past(active) |-> osc_trim == 5'sh00) // [R7]
        else $error("Oscillator trim moved outside a burst");
endmodule : spread_dither

// ---- touch_detect_output_drift.sv ----
// Burst pacing, drift-tracked reference, detection filter and output pin
`timescale 1ns/1ps
`include "touch_detect_regs.svh"
// Functional notes
// R1 - No recalibration input; full recalibration only at reset and on timeout.
// R2 - Host may force recalibration by cycling the device supply.
// R3 - Without detection, reference creeps toward raw signal, one count per step.
// R4 - Threshold and hysteresis levels are offsets from the live reference.
// R5 - Reference frozen while a detection is in effect.
// R6 - Reference follows falling signals faster than rising ones.
// R7 - Oscillator trim spreads burst frequency by up to 7.5 percent.
// R8 - Output high on confirmed detection, low otherwise.
// R9 - Output stays high until detection ends or max on-duration expires.
// R10 - Max on-duration expiry recalibrates and holds output low until new detection.
// R11 - Output released to high impedance 15 us before every burst.
// R12 - Host may pull up and count liveness pulses while idle.
// R13 - Host may switch its load to see pulses in both states.
// R14 - Host ignores the output for about 100 ms after power-up. The host model waits only SETTLE_CYC = 16 clocks.
// R15 - Candidate when signal exceeds reference by 10; release with hysteresis 2.
// R16 - Outside sync mode, four consecutive hits assert output; a miss clears.
// R17 - Max on-duration counts bursts, not time.
// R18 - Sleep-paced mode idles 80 ms between bursts, fast while resolving.
// R19 - Burst count compared against reference plus threshold in one cycle.
// R20 - Timeouts are burst-count parameters near nominal sleep-paced times.
module touch_detect_output_drift #(
    parameter int FAST_GAP_CYC = `TD_FAST_GAP_CYC,
    parameter int SLEEP_GAP_CYC = `TD_SLEEP_GAP_CYC,
    parameter int MAX_ON_BURSTS = `TD_MAX_ON_BURSTS // [R20]
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Pacing mode
    input wire logic sleep_paced_mode,
    input wire logic sync_mode,
    input wire logic sync_trigger,
    // Measurement front end
    output logic burst_start,
    input wire logic burst_done,
    input wire logic [`TD_CNT_W-1:0] burst_count,
    output logic signed [4:0] osc_trim,
    // Detection output pin
    output logic detect_out,
    output logic detect_oe,
    // Status
    output logic calibrating
);
    touch_detect_pkg::detect_s q, d;
    logic hit;
    logic signed [4:0] trim_w;

    // Level test shared by threshold and hysteresis decisions
    function automatic logic above(input logic [`TD_CNT_W-1:0] cnt, input logic [`TD_CNT_W-1:0] lvl,
                                   input logic [`TD_CNT_W-1:0] margin);
        above = {1'b0, cnt} > ({1'b0, lvl} + {1'b0, margin});
    endfunction : above

    // While detecting, release needs the signal to fall two counts below the threshold
    assign hit = q.out ? above(burst_count, q.ref_lvl, `TD_THRESH - `TD_HYST) // [R4] [R15] [R19]
                       : above(burst_count, q.ref_lvl, `TD_THRESH); // [R15] [R19]

    always_comb
    begin
        d = q;
        burst_start = 1'b0;
        unique case (q.st)
            touch_detect_pkg::PACE_GAP:
            begin
                if (sync_mode ? sync_trigger : (q.timer == '0))
                begin
                    d.st = touch_detect_pkg::PACE_LIVE;
                    d.timer = `TD_TIMER_W'(`TD_LIVE_CYC - 1); // [R11]
                end
                else if (q.timer != '0)
                begin
                    d.timer = q.timer - 1'b1;
                end
            end
            touch_detect_pkg::PACE_LIVE:
            begin
                if (q.timer == '0)
                begin
                    d.st = touch_detect_pkg::PACE_BURST;
                    burst_start = 1'b1;
                end
                else
                begin
                    d.timer = q.timer - 1'b1;
                end
            end
            touch_detect_pkg::PACE_BURST:
            begin
                if (burst_done)
                begin
                    d.st = touch_detect_pkg::PACE_GAP;
                    if (q.cal)
                    begin
                        // First burst after reset or timeout becomes the new reference
                        d.ref_lvl = burst_count; // [R1] [R10]
                        d.cal = 1'b0;
                        d.di = 3'h0;
                        d.drift_cnt = 5'h00;
                    end
                    else if (q.out)
                    begin
                        if (!hit)
                        begin
                            d.out = 1'b0; // [R9]
                            d.on_cnt = '0;
                        end
                        else if (q.on_cnt == `TD_ON_W'(MAX_ON_BURSTS - 1))
                        begin
                            d.out = 1'b0; // [R10]
                            d.cal = 1'b1; // [R1] [R10]
                            d.on_cnt = '0;
                        end
                        else
                        begin
                            d.on_cnt = q.on_cnt + 1'b1; // [R17]
                        end
                    end
                    else if (hit)
                    begin
                        d.drift_cnt = 5'h00; // [R5]
                        if (sync_mode || q.di == `TD_CONSENSUS - 3'h1)
                        begin
                            d.out = 1'b1; // [R8] [R16]
                            d.di = 3'h0;
                        end
                        else
                        begin
                            d.di = q.di + 3'h1; // [R16]
                        end
                    end
                    else
                    begin
                        d.di = 3'h0; // [R16]
                        if (burst_count == q.ref_lvl)
                        begin
                            d.drift_cnt = 5'h00;
                        end
                        else if (q.drift_cnt >= ((burst_count < q.ref_lvl) ? `TD_DRIFT_DOWN_BURSTS
                                                                             : `TD_DRIFT_UP_BURSTS) - 5'h01)
                        begin
                            // One count per step keeps a slow approach from being absorbed
                            d.ref_lvl = (burst_count < q.ref_lvl) ? q.ref_lvl - 1'b1 : q.ref_lvl + 1'b1; // [R3] [R6]
                            d.drift_cnt = 5'h00;
                        end
                        else
                        begin
                            d.drift_cnt = q.drift_cnt + 5'h01; // [R6]
                        end
                    end
                    // Fast pacing while the consensus filter is resolving
                    if (sleep_paced_mode && d.di == 3'h0)
                        d.timer = `TD_TIMER_W'(SLEEP_GAP_CYC - 1); // [R18]
                    else
                        d.timer = `TD_TIMER_W'(FAST_GAP_CYC - 1); // [R18]
                end
            end
            default:
            begin
                d.st = touch_detect_pkg::PACE_GAP;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            q.st <= touch_detect_pkg::PACE_GAP;
            q.timer <= '0;
            q.ref_lvl <= '0;
            q.di <= 3'h0;
            q.out <= 1'b0;
            q.cal <= 1'b1; // [R1]
            q.on_cnt <= '0;
            q.drift_cnt <= 5'h00;
        end
        else
        begin
            q <= d;
        end
    end

    spread_dither u_dither (
        .clk(clk),
        .reset(reset),
        .active(q.st == touch_detect_pkg::PACE_BURST),
        .osc_trim(trim_w)
    );

    assign osc_trim = trim_w;
    assign detect_out = q.out; // [R8]
    assign detect_oe = (q.st != touch_detect_pkg::PACE_LIVE); // [R11]
    assign calibrating = q.cal;

    // Checking helpers
    logic [9:0] live_len_q;
    always_ff @(posedge clk)
    begin
        if (reset || detect_oe)
            live_len_q <= 10'h000;
        else
            live_len_q <= live_len_q + 10'h001;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // The counter still holds the full low time when the rise of the enable is sampled
    a_liveness_width: assert property ($rose(detect_oe) && $past(!reset) |-> // [R11]
                                       live_len_q == 10'(`TD_LIVE_CYC))
        else $error("Liveness release not 15 us long");
    a_burst_after_live: assert property (burst_start |-> !detect_oe ##1 detect_oe) // [R11]
        else $error("Burst started without preceding liveness release");
    a_ref_frozen: assert property (q.out && $past(q.out) |-> $stable(q.ref_lvl)) // [R5]
        else $error("Reference moved during detection");
    a_consensus_four: assert property ($rose(q.out) && !$past(sync_mode) |-> $past(q.di) == 3'h3) // [R16]
        else $error("Output asserted without four consecutive hits");
    a_out_needs_hit: assert property ($rose(q.out) |-> $past(burst_done && hit)) // [R8] [R15]
        else $error("Output asserted without a detecting burst");
    a_maxon_recal: assert property (burst_done && q.st == touch_detect_pkg::PACE_BURST && q.out && hit && // [R10]
                                    q.on_cnt == `TD_ON_W'(MAX_ON_BURSTS - 1) |=> !q.out && q.cal ##1 !q.out)
        else $error("Max on-duration expiry did not recalibrate");
    a_drift_slew: assert property ($changed(q.ref_lvl) && !$past(q.cal) |-> // [R3]
                                   (q.ref_lvl - $past(q.ref_lvl) == 1) || ($past(q.ref_lvl) - q.ref_lvl == 1))
        else $error("Reference stepped more than one count");
    a_miss_clears: assert property (burst_done && q.st == touch_detect_pkg::PACE_BURST && !hit && !q.cal |=> // [R16]
                                    q.di == 3'h0 && !q.out)
        else $error("Missed burst did not clear consensus counter");

    c_out_rise: cover property ($rose(detect_out));
    c_maxon_recal: cover property ($rose(q.cal));
    c_drift_down: cover property (!q.cal && $past(!q.cal) && q.ref_lvl < $past(q.ref_lvl));
    c_liveness: cover property ($rose(detect_oe));
endmodule : touch_detect_output_drift

// ---- host_monitor.sv ----
// Host model: pull-up on the detection pin, counts and times liveness pulses
`timescale 1ns/1ps
module host_monitor #(
    parameter int SETTLE_CYC = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Detection pin
    input wire logic detect_out,
    input wire logic detect_oe,
    // Observations
    output logic pin_level,
    output logic [15:0] pulse_count,
    output logic [15:0] pulse_width,
    output logic [15:0] load_pulses
);
    logic [15:0] run_len;
    logic [15:0] age;
    logic pin_prev;
    logic sw_level;
    logic sw_prev;

    // Switched load sits opposite the driven level, so a release shows in both states
    assign sw_level = detect_oe ? detect_out : !detect_out;

    // Pull-up only shows while the device has let go of the pin
    assign pin_level = detect_oe ? detect_out : 1'b1;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            pin_prev <= 1'b0;
            sw_prev <= 1'b0;
            load_pulses <= 16'h0000;
            age <= 16'h0000;
            run_len <= 16'h0000;
            pulse_count <= 16'h0000;
            pulse_width <= 16'h0000;
        end
        else
        begin
            pin_prev <= pin_level;
            sw_prev <= sw_level;
            if (sw_level != sw_prev && !detect_oe && age == SETTLE_CYC[15:0])
                load_pulses <= load_pulses + 16'h0001;
            // Level is not trusted until power-up settles
            if (age != SETTLE_CYC[15:0])
                age <= age + 16'h0001;
            if (pin_level && !pin_prev)
            begin
                run_len <= 16'h0001;
                if (age == SETTLE_CYC[15:0])
                    pulse_count <= pulse_count + 16'h0001;
            end
            else if (pin_level)
                run_len <= run_len + 16'h0001;
            if (!pin_level && pin_prev)
                pulse_width <= run_len;
        end
    end
endmodule : host_monitor

// ---- touch_detect_output_drift_bench.sv ----
// Self-checking bench for the touch detection output and drift block
`timescale 1ns/1ps
`include "touch_detect_regs.svh"
module touch_detect_output_drift_bench;
    localparam int MAX_ON = 5;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic sleep_paced_mode = 1'b0;
    logic sync_mode = 1'b0;
    logic sync_trigger = 1'b0;
    logic burst_done = 1'b0;
    logic [`TD_CNT_W-1:0] burst_count = 14'h0000;
    logic burst_start;
    logic signed [4:0] osc_trim;
    logic detect_out;
    logic detect_oe;
    logic calibrating;
    logic pin_level;
    logic [15:0] pulse_count;
    logic [15:0] pulse_width;
    logic [15:0] saved;
    logic [15:0] load_pulses;
    logic [15:0] saved_load;
    int err_count = 0;
    int checked = 0;
    int cyc = 0;
    int gap = 0;

    always #12.5 clk = ~clk;

    touch_detect_output_drift #(.FAST_GAP_CYC(50), .SLEEP_GAP_CYC(200), .MAX_ON_BURSTS(MAX_ON)) uut (
        .clk(clk), .reset(reset), .sleep_paced_mode(sleep_paced_mode), .sync_mode(sync_mode),
        .sync_trigger(sync_trigger), .burst_start(burst_start), .burst_done(burst_done),
        .burst_count(burst_count), .osc_trim(osc_trim), .detect_out(detect_out),
        .detect_oe(detect_oe), .calibrating(calibrating));

    host_monitor host (.clk(clk), .reset(reset), .detect_out(detect_out), .detect_oe(detect_oe),
        .pin_level(pin_level), .pulse_count(pulse_count), .pulse_width(pulse_width),
        .load_pulses(load_pulses));

    task results;
        if (err_count == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results

    // A hung handshake ends up here rather than running forever
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            err_count = err_count + 1;
            results();
        end
    end

    task chk(input logic [15:0] got, input logic [15:0] exp);
        checked = checked + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task burst(input logic [13:0] cnt, input logic exp_out, input logic exp_cal);
        logic was_low;
        gap = 0;
        @(posedge clk);
        #1;
        while (burst_start !== 1'b1 && gap < 3000)
        begin
            @(posedge clk);
            #1;
            gap = gap + 1;
        end
        was_low = (detect_out === 1'b0);
        @(posedge clk);
        burst_done <= 1'b1;
        burst_count <= cnt;
        @(posedge clk);
        burst_done <= 1'b0;
        chk({15'h0000, osc_trim === 5'h10}, 16'h0000);
        repeat (2) @(posedge clk);
        #1;
        chk({11'h000, osc_trim}, 16'h0000);
        if (was_low)
            chk(pulse_width, 16'h0258);
        chk({14'h0000, detect_out, calibrating}, {14'h0000, exp_out, exp_cal});
    endtask : burst

    task sync_burst(input logic [13:0] cnt, input logic exp_out);
        @(posedge clk);
        sync_trigger <= 1'b1;
        @(posedge clk);
        sync_trigger <= 1'b0;
        burst(cnt, exp_out, 1'b0);
    endtask : sync_burst

    initial
    begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        #1;
        chk({13'h0000, detect_out, detect_oe, calibrating}, 16'h0003);
        burst(14'h03E8, 1'b0, 1'b0);
        repeat (4) burst(14'h03F2, 1'b0, 1'b0);
        repeat (3) burst(14'h03F3, 1'b0, 1'b0);
        burst(14'h03E8, 1'b0, 1'b0);
        repeat (3) burst(14'h03F3, 1'b0, 1'b0);
        burst(14'h03F3, 1'b1, 1'b0);
        saved = pulse_count;
        saved_load = load_pulses;
        burst(14'h03F1, 1'b1, 1'b0);
        chk(pulse_count, saved);
        chk(load_pulses, saved_load + 16'h0001);
        burst(14'h03F0, 1'b0, 1'b0);
        repeat (3) burst(14'h03F3, 1'b0, 1'b0);
        burst(14'h03F3, 1'b1, 1'b0);
        repeat (MAX_ON - 1) burst(14'h03F3, 1'b1, 1'b0);
        burst(14'h03F3, 1'b0, 1'b1);
        burst(14'h044C, 1'b0, 1'b0);
        // Rising signal must not move the reference within two bursts
        repeat (2) burst(14'h0451, 1'b0, 1'b0);
        burst(14'h044C, 1'b0, 1'b0);
        repeat (2) burst(14'h0442, 1'b0, 1'b0);
        repeat (3) burst(14'h0456, 1'b0, 1'b0);
        burst(14'h0456, 1'b1, 1'b0);
        burst(14'h044B, 1'b0, 1'b0);
        @(posedge clk);
        sync_mode <= 1'b1;
        saved = pulse_count;
        repeat (700) @(posedge clk);
        chk(pulse_count, saved);
        sync_burst(14'h0456, 1'b1);
        sync_burst(14'h044B, 1'b0);
        @(posedge clk);
        sync_mode <= 1'b0;
        sleep_paced_mode <= 1'b1;
        saved = pulse_count;
        repeat (2) burst(14'h044B, 1'b0, 1'b0);
        chk({15'h0000, gap > 720}, 16'h0001);
        chk(pulse_count, saved + 16'h0002);
        repeat (2) burst(14'h0456, 1'b0, 1'b0);
        chk({15'h0000, gap < 720}, 16'h0001);
        // Host cycles the supply: the block must come back calibrating
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        #1;
        chk({13'h0000, detect_out, detect_oe, calibrating}, 16'h0003);
        burst(14'h0400, 1'b0, 1'b0);
        results();
    end
endmodule : touch_detect_output_drift_bench
